// ---- rtl/flash_bus_cycle.v ----
// One asynchronous flash bus cycle: a write strobe or a read with data capture
`include "flash_prot_regs.vh"

module flash_bus_cycle #(
	parameter ADDR_W = 23
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	// Request from the sequencer
	input wire start,
	input wire isRead,
	input wire [ADDR_W-1:0] addr,
	input wire [15:0] wdata,
	output reg done,
	output reg [15:0] rdWord,
	// Flash pins
	output reg [ADDR_W-1:0] flashAddr,
	output reg [15:0] dqOut,
	output reg dqOe,
	input wire [15:0] dqIn,
	output reg ceN,
	output reg weN,
	output reg oeN
);
	localparam [3:0] E_IDLE = 4'h1;
	localparam [3:0] E_SETUP = 4'h2;
	localparam [3:0] E_PULSE = 4'h4;
	localparam [3:0] E_HOLD = 4'h8;
	localparam integer SETUP_I = `ADDR_SETUP_CYC;
	localparam integer WE_I = `WE_LOW_CYC;
	localparam integer RD_I = `READ_ACC_CYC;
	localparam integer HOLD_I = `HOLD_CYC;
	// Cut to the counter width on purpose; every count stays below 256
	localparam [7:0] SETUP_N = SETUP_I[7:0];
	localparam [7:0] WE_N = WE_I[7:0];
	localparam [7:0] RD_N = RD_I[7:0];
	localparam [7:0] HOLD_N = HOLD_I[7:0];

	reg [3:0] state_r;
	reg [7:0] cnt_r;
	reg rd_r;
	reg [15:0] dqSync1_r;
	reg [15:0] dqSync2_r;

	// ----------------------------------------
	// Pin data synchroniser
	// ----------------------------------------
	always @(posedge clock) begin
		dqSync1_r <= dqIn;
		dqSync2_r <= dqSync1_r;
	end

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			state_r <= E_IDLE;
			cnt_r <= 8'h00;
			rd_r <= 1'b0;
			done <= 1'b0;
			rdWord <= 16'h0000;
			flashAddr <= {ADDR_W{1'b0}};
			dqOut <= 16'h0000;
			dqOe <= 1'b0;
			ceN <= 1'b1;
			weN <= 1'b1;
			oeN <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state_r)
				E_IDLE: begin
					if (start) begin
						rd_r <= isRead;
						flashAddr <= addr;
						dqOut <= wdata;
						dqOe <= ~isRead;
						ceN <= 1'b0;
						cnt_r <= SETUP_N;
						state_r <= E_SETUP;
					end
				end
				E_SETUP: begin
					if (cnt_r <= 8'h01) begin
						weN <= rd_r;
						oeN <= ~rd_r;
						cnt_r <= rd_r ? RD_N : WE_N;
						state_r <= E_PULSE;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				E_PULSE: begin
					if (cnt_r <= 8'h01) begin
						// Command latched on the rising edge of the write strobe
						if (rd_r)
							rdWord <= dqSync2_r;
						weN <= 1'b1;
						oeN <= 1'b1;
						cnt_r <= HOLD_N;
						state_r <= E_HOLD;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				E_HOLD: begin
					if (cnt_r <= 8'h01) begin
						ceN <= 1'b1;
						dqOe <= 1'b0;
						done <= 1'b1;
						state_r <= E_IDLE;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: begin
					state_r <= E_IDLE;
				end
			endcase
		end
	end
endmodule // flash_bus_cycle

// ---- rtl/flash_prot_host.v ----
// Host controller issuing protection command sequences to a parallel NOR flash
//
// Our own choices: the address map and the APB register port.
`include "flash_prot_regs.vh"

module flash_prot_host #(
	parameter ADDR_W = 23
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Flash pins
	output wire [ADDR_W-1:0] flashAddr,
	output wire [15:0] dqOut,
	output wire dqOe,
	input wire [15:0] dqIn,
	output wire ceN,
	output wire weN,
	output wire oeN,
	output reg flashRstN,
	output reg byteN
);
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_GAP = 5'h02;
	localparam [4:0] S_RUN = 5'h04;
	localparam [4:0] S_SETTLE = 5'h08;
	localparam [4:0] S_RST = 5'h10;
	localparam integer GAP_I = `UNLOCK_GAP_CYC;
	localparam integer RSTLOW_I = `RST_LOW_CYC;
	localparam integer RSTREC_I = `RST_REC_CYC;
	// Cut to the wait counter width on purpose; every count stays below 1024
	localparam [9:0] GAP_N = GAP_I[9:0];
	localparam [9:0] RSTLOW_N = RSTLOW_I[9:0];
	localparam [9:0] RSTREC_N = RSTREC_I[9:0];
	localparam AW = ADDR_W;

	reg [4:0] state_r;
	reg [4:0] cmd_r;
	reg [2:0] mode_r;
	reg [3:0] idx_r;
	reg [9:0] wait_r;
	reg [9:0] gap_r;
	reg refused_r;
	reg startEng_r;
	reg [ADDR_W-1:0] addr_r;
	reg [15:0] data_r;
	reg [63:0] pw_r;
	reg [63:0] pwRead_r;
	reg [15:0] rdat_r;
	reg rstPhase_r;
	wire engDone;
	wire [15:0] engWord;
	wire [AW+17:0] step;
	wire stepLast;
	wire stepRead;
	wire [AW-1:0] stepAddr;
	wire [15:0] stepData;
	wire apbAccess;
	wire cmdWrite;
	wire [4:0] newCmd;
	wire cmdOk;

	// ----------------------------------------
	// Sequence tables
	// ----------------------------------------
	// Packs {last, read, address, data}
	function [AW+17:0] pack;
		input last;
		input rd;
		input [AW-1:0] a;
		input [15:0] d;
		begin
			pack = {last, rd, a, d};
		end
	endfunction

	// Three-write set entry: two unlock writes then the set code
	function [AW+17:0] entry;
		input [3:0] i;
		input [15:0] code;
		begin
			case (i)
				4'h0: entry = pack(1'b0, 1'b0, `FL_ADDR1, `FL_UNLK1);
				4'h1: entry = pack(1'b0, 1'b0, `FL_ADDR2, `FL_UNLK2);
				default: entry = pack(1'b1, 1'b0, `FL_ADDR1, code);
			endcase
		end
	endfunction

	// Two-write command: a lead code then address and data
	function [AW+17:0] pair;
		input [3:0] i;
		input [15:0] lead;
		input [AW-1:0] a;
		input [15:0] d;
		begin
			if (i == 4'h0)
				pair = pack(1'b0, 1'b0, {AW{1'b0}}, lead);
			else
				pair = pack(1'b1, 1'b0, a, d);
		end
	endfunction

	function [15:0] pwWord;
		input [63:0] pw;
		input [1:0] w;
		begin
			pwWord = pw[{w, 4'h0} +: 16];
		end
	endfunction

	function [AW+17:0] seqStep;
		input [4:0] c;
		input [3:0] i;
		input [AW-1:0] a;
		input [15:0] d;
		input [63:0] pw;
		begin
			case (c)
				`CMD_ENTER_EXT: seqStep = entry(i, `FL_SET_EXT);
				`CMD_EXIT_EXT: begin
					if (i < 4'h2)
						seqStep = entry(i, `FL_EXIT1);
					else if (i == 4'h2)
						seqStep = pack(1'b0, 1'b0, `FL_ADDR1, `FL_EXIT1);
					else
						seqStep = pack(1'b1, 1'b0, {AW{1'b0}}, `FL_EXIT2);
				end
				`CMD_ENTER_LREG: seqStep = entry(i, `FL_SET_LREG);
				`CMD_LREG_PROG: seqStep = pair(i, `FL_PROG, {AW{1'b0}}, d);
				`CMD_ENTER_PW: seqStep = entry(i, `FL_SET_PW);
				`CMD_PW_PROG: begin
					if (!i[0])
						seqStep = pack(1'b0, 1'b0, {AW{1'b0}}, `FL_PROG);
					else
						seqStep = pack(i == 4'h7, 1'b0, {{(AW-2){1'b0}}, i[2:1]},
							pwWord(pw, i[2:1]));
				end
				`CMD_PW_READ: seqStep = pack(i == 4'h3, 1'b1, {{(AW-2){1'b0}}, i[1:0]},
					16'h0000);
				`CMD_PW_UNLOCK: begin
					if (i == 4'h0)
						seqStep = pack(1'b0, 1'b0, {AW{1'b0}}, `FL_PWUL1);
					else if (i == 4'h1)
						seqStep = pack(1'b0, 1'b0, {AW{1'b0}}, `FL_PWUL2);
					else if (i < 4'h6)
						seqStep = pack(1'b0, 1'b0, {{(AW-2){1'b0}}, i[1:0] - 2'h2},
							pwWord(pw, i[1:0] - 2'h2));
					else
						seqStep = pack(1'b1, 1'b0, {AW{1'b0}}, `FL_PWUL3);
				end
				`CMD_ENTER_NVP: seqStep = entry(i, `FL_SET_NVP);
				`CMD_NVP_PROG: seqStep = pair(i, `FL_PROG, a, `FL_BIT_ZERO);
				`CMD_NVP_CLRALL: seqStep = pair(i, `FL_ERASE, {AW{1'b0}}, `FL_CLRALL);
				`CMD_ENTER_FRZ: seqStep = entry(i, `FL_SET_FRZ);
				`CMD_FRZ_PROG: seqStep = pair(i, `FL_PROG, {AW{1'b0}}, `FL_BIT_ZERO);
				`CMD_ENTER_VOL: seqStep = entry(i, `FL_SET_VOL);
				`CMD_VOL_PROG: seqStep = pair(i, `FL_PROG, a, `FL_BIT_ZERO);
				`CMD_VOL_CLR: seqStep = pair(i, `FL_PROG, a, `FL_BIT_ONE);
				`CMD_EXIT_PROT: seqStep = pair(i, `FL_EXIT1, {AW{1'b0}}, `FL_EXIT2);
				`CMD_NVP_READ, `CMD_VOL_READ: seqStep = pack(1'b1, 1'b1, a, 16'h0000);
				// Lock register, freeze status and array reads use the given address
				default: seqStep = pack(1'b1, 1'b1, a, 16'h0000);
			endcase
		end
	endfunction

	// Which commands are legal in each tracked mode
	function allowed;
		input [4:0] c;
		input [2:0] m;
		begin
			case (c)
				`CMD_ENTER_EXT, `CMD_ENTER_LREG, `CMD_ENTER_PW, `CMD_ENTER_NVP,
				`CMD_ENTER_FRZ, `CMD_ENTER_VOL: allowed = (m == `MODE_NORMAL);
				`CMD_EXIT_EXT: allowed = (m == `MODE_EXT);
				`CMD_ARRAY_READ: allowed = (m == `MODE_NORMAL) || (m == `MODE_EXT);
				`CMD_LREG_PROG, `CMD_LREG_READ: allowed = (m == `MODE_LREG);
				`CMD_PW_PROG, `CMD_PW_READ, `CMD_PW_UNLOCK: allowed = (m == `MODE_PW);
				`CMD_NVP_PROG, `CMD_NVP_CLRALL, `CMD_NVP_READ: allowed = (m == `MODE_NVP);
				`CMD_FRZ_PROG, `CMD_FRZ_READ: allowed = (m == `MODE_FRZ);
				`CMD_VOL_PROG, `CMD_VOL_READ, `CMD_VOL_CLR: allowed = (m == `MODE_VOL);
				`CMD_EXIT_PROT: allowed = (m >= `MODE_LREG);
				`CMD_HW_RESET: allowed = 1'b1;
				// Unknown codes are refused; the one erase, CMD_NVP_CLRALL, is legal only in MODE_NVP, so never in extended mode
				default: allowed = 1'b0;
			endcase
		end
	endfunction

	function [2:0] modeAfter;
		input [4:0] c;
		input [2:0] m;
		begin
			case (c)
				`CMD_ENTER_EXT: modeAfter = `MODE_EXT;
				`CMD_ENTER_LREG: modeAfter = `MODE_LREG;
				`CMD_ENTER_PW: modeAfter = `MODE_PW;
				`CMD_ENTER_NVP: modeAfter = `MODE_NVP;
				`CMD_ENTER_FRZ: modeAfter = `MODE_FRZ;
				`CMD_ENTER_VOL: modeAfter = `MODE_VOL;
				`CMD_EXIT_EXT, `CMD_EXIT_PROT: modeAfter = `MODE_NORMAL;
				default: modeAfter = m;
			endcase
		end
	endfunction

	assign step = seqStep(cmd_r, idx_r, addr_r, data_r, pw_r);
	assign stepLast = step[AW+17];
	assign stepRead = step[AW+16];
	assign stepAddr = step[AW+15:16];
	assign stepData = step[15:0];
	assign apbAccess = psel && penable && !pready;
	assign cmdWrite = apbAccess && pwrite && (paddr == `REG_CMD);
	assign newCmd = pwdata[4:0];
	assign cmdOk = (state_r == S_IDLE) && allowed(newCmd, mode_r);

	// ----------------------------------------
	// Bus cycle engine
	// ----------------------------------------
	flash_bus_cycle #(
		.ADDR_W(ADDR_W)
	) u_cycle (
		.clock(clock),
		.rst(rst),
		.start(startEng_r),
		.isRead(stepRead),
		.addr(stepAddr),
		.wdata(stepData),
		.done(engDone),
		.rdWord(engWord),
		.flashAddr(flashAddr),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.dqIn(dqIn),
		.ceN(ceN),
		.weN(weN),
		.oeN(oeN)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			state_r <= S_IDLE;
			cmd_r <= 5'h00;
			mode_r <= `MODE_NORMAL;
			idx_r <= 4'h0;
			wait_r <= 10'h000;
			gap_r <= 10'h000;
			startEng_r <= 1'b0;
			pwRead_r <= {64{1'b1}};
			rdat_r <= 16'h0000;
			rstPhase_r <= 1'b0;
			flashRstN <= 1'b1;
			byteN <= 1'b1;
		end else begin
			startEng_r <= 1'b0;
			if (gap_r != 10'h000)
				gap_r <= gap_r - 10'h001;
			case (state_r)
				S_IDLE: begin
					if (cmdWrite && cmdOk) begin
						cmd_r <= newCmd;
						idx_r <= 4'h0;
						if (newCmd == `CMD_HW_RESET) begin
							flashRstN <= 1'b0;
							rstPhase_r <= 1'b0;
							wait_r <= RSTLOW_N;
							state_r <= S_RST;
						end else begin
							state_r <= S_GAP;
						end
					end
				end
				S_GAP: begin
					// Early unlock is held back rather than sent and lost
					if (cmd_r != `CMD_PW_UNLOCK || gap_r == 10'h000) begin
						startEng_r <= 1'b1;
						state_r <= S_RUN;
					end
				end
				S_RUN: begin
					if (engDone) begin
						if (stepRead) begin
							rdat_r <= engWord;
							if (cmd_r == `CMD_PW_READ)
								pwRead_r[{idx_r[1:0], 4'h0} +: 16] <= engWord;
						end
						if (stepLast) begin
							mode_r <= modeAfter(cmd_r, mode_r);
							if (cmd_r == `CMD_PW_UNLOCK) begin
								gap_r <= GAP_N;
								wait_r <= GAP_N;
								state_r <= S_SETTLE;
							end else begin
								state_r <= S_IDLE;
							end
						end else begin
							idx_r <= idx_r + 4'h1;
							startEng_r <= 1'b1;
						end
					end
				end
				S_SETTLE: begin
					// Busy stays up while the device finishes unlocking
					if (wait_r <= 10'h001)
						state_r <= S_IDLE;
					else
						wait_r <= wait_r - 10'h001;
				end
				S_RST: begin
					if (wait_r > 10'h001) begin
						wait_r <= wait_r - 10'h001;
					end else if (!rstPhase_r) begin
						flashRstN <= 1'b1;
						rstPhase_r <= 1'b1;
						wait_r <= RSTREC_N;
					end else begin
						mode_r <= `MODE_NORMAL;
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// APB registers
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			addr_r <= {ADDR_W{1'b0}};
			data_r <= 16'h0000;
			pw_r <= {64{1'b1}};
			refused_r <= 1'b0;
		end else begin
			pready <= apbAccess;
			pslverr <= 1'b0;
			if (apbAccess) begin
				prdata <= 32'h00000000;
				case (paddr)
					`REG_CMD: prdata <= {27'h0000000, cmd_r};
					`REG_ADDR: prdata <= {{(32-ADDR_W){1'b0}}, addr_r};
					`REG_DATA: prdata <= {16'h0000, data_r};
					`REG_PWLO: prdata <= pw_r[31:0];
					`REG_PWHI: prdata <= pw_r[63:32];
					`REG_STAT: prdata <= {25'h0000000, mode_r, 2'h0, refused_r,
						state_r != S_IDLE};
					`REG_RDAT: prdata <= {16'h0000, rdat_r};
					`REG_PRLO: prdata <= pwRead_r[31:0];
					`REG_PRHI: prdata <= pwRead_r[63:32];
					default: pslverr <= 1'b1;
				endcase
				if (pwrite) begin
					case (paddr)
						`REG_ADDR: addr_r <= pwdata[ADDR_W-1:0];
						`REG_DATA: data_r <= pwdata[15:0];
						`REG_PWLO: pw_r[31:0] <= pwdata;
						`REG_PWHI: pw_r[63:32] <= pwdata;
						default: ;
					endcase
				end
			end
			// A new refusal wins over a write-one clear in the same cycle
			if (cmdWrite && !cmdOk)
				refused_r <= 1'b1;
			else if (apbAccess && pwrite && paddr == `REG_STAT && pwdata[`STAT_REFUSED])
				refused_r <= 1'b0;
		end
	end
endmodule // flash_prot_host

// ---- rtl/flash_prot_regs.vh ----
// Register map, command codes, flash bus codes and timing counts for the protection host
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_PWLO 8'h0C
`define REG_PWHI 8'h10
`define REG_STAT 8'h14
`define REG_RDAT 8'h18
`define REG_PRLO 8'h1C
`define REG_PRHI 8'h20

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_MODE_LO 4

// ----------------------------------------
// Host command codes
// ----------------------------------------
`define CMD_ENTER_EXT 5'h01
`define CMD_EXIT_EXT 5'h02
`define CMD_ENTER_LREG 5'h03
`define CMD_LREG_PROG 5'h04
`define CMD_LREG_READ 5'h05
`define CMD_ENTER_PW 5'h06
`define CMD_PW_PROG 5'h07
`define CMD_PW_READ 5'h08
`define CMD_PW_UNLOCK 5'h09
`define CMD_ENTER_NVP 5'h0A
`define CMD_NVP_PROG 5'h0B
`define CMD_NVP_CLRALL 5'h0C
`define CMD_NVP_READ 5'h0D
`define CMD_ENTER_FRZ 5'h0E
`define CMD_FRZ_PROG 5'h0F
`define CMD_FRZ_READ 5'h10
`define CMD_ENTER_VOL 5'h11
`define CMD_VOL_PROG 5'h12
`define CMD_VOL_READ 5'h13
`define CMD_VOL_CLR 5'h14
`define CMD_EXIT_PROT 5'h15
`define CMD_ARRAY_READ 5'h16
`define CMD_HW_RESET 5'h17

// ----------------------------------------
// Tracked device modes
// ----------------------------------------
`define MODE_NORMAL 3'h0
`define MODE_EXT 3'h1
`define MODE_LREG 3'h2
`define MODE_PW 3'h3
`define MODE_NVP 3'h4
`define MODE_FRZ 3'h5
`define MODE_VOL 3'h6

// ----------------------------------------
// Flash bus codes (16-bit mode)
// ----------------------------------------
`define FL_ADDR1 23'h000555
`define FL_ADDR2 23'h0002AA
`define FL_UNLK1 16'h00AA
`define FL_UNLK2 16'h0055
`define FL_SET_EXT 16'h0088
`define FL_SET_LREG 16'h0040
`define FL_SET_PW 16'h0060
`define FL_SET_NVP 16'h00C0
`define FL_SET_FRZ 16'h0050
`define FL_SET_VOL 16'h00E0
`define FL_PROG 16'h00A0
`define FL_ERASE 16'h0080
`define FL_CLRALL 16'h0030
`define FL_EXIT1 16'h0090
`define FL_EXIT2 16'h0000
`define FL_BIT_ZERO 16'h0000
`define FL_BIT_ONE 16'h0001
`define FL_PWUL1 16'h0025
`define FL_PWUL2 16'h0003
`define FL_PWUL3 16'h0029

// ----------------------------------------
// Timing, ns and derived cycles at 4 ns
// ----------------------------------------
`define CLK_NS 4
`define UNLOCK_GAP_NS 1000
`define UNLOCK_GAP_CYC ((`UNLOCK_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define ADDR_SETUP_NS 10
`define ADDR_SETUP_CYC ((`ADDR_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define WE_LOW_NS 35
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define READ_ACC_NS 70
`define READ_ACC_CYC ((`READ_ACC_NS + `CLK_NS - 1) / `CLK_NS + 2)
`define HOLD_NS 20
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_LOW_NS 500
`define RST_LOW_CYC ((`RST_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_REC_NS 200
`define RST_REC_CYC ((`RST_REC_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- tb/flash_model.sv ----
// Behavioural model of the flash protection command decoder
module flash_model #(
	parameter PWL = 2
) (
	input wire logic ceN,
	input wire logic weN,
	input wire logic oeN,
	input wire logic flashRstN,
	input wire logic [22:0] flashAddr,
	input wire logic [15:0] dqOut,
	output logic [15:0] dqIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] mode = 3'h0;
	logic [38:0] h1 = 39'h0, h2 = 39'h0;
	logic pg = 0, er = 0, ex = 0, frz = 1;
	logic [15:0] lreg = 16'hFFFF, q = 16'h0000;
	logic [63:0] pw = {4{16'hFFFF}}, tr = 64'h0;
	logic [15:0] ext [logic [6:0]];
	logic nv [logic [22:0]];
	logic vb [logic [22:0]];
	int uc = 0;
	time tu = 0;
	wire [22:0] a = flashAddr;
	wire [15:0] d = dqOut;
	// Released bus shows the inverse so a stale capture cannot match
	assign dqIn = oeN ? ~q : q;
	always @(posedge weN) if (!ceN) begin
		if (pg) begin
			pg = 0;
			case (mode)
				1: if (lreg[0]) ext[a[6:0]] = (ext.exists(a[6:0]) ? ext[a[6:0]] : 16'hFFFF) & d;
				2: lreg = lreg & d;
				3: pw[a[1:0]*16 +: 16] = d;
				4: nv[a] = 1'b1;
				5: frz = 1'b0;
				6: vb[a] = d[0];
			endcase
		end else if (uc == 1) uc = (d == 16'h0003) ? 2 : 0;
		else if (uc > 1 && uc < 6) begin
			tr[a[1:0]*16 +: 16] = d;
			uc++;
		end else if (uc == 6) begin
			uc = 0;
			if (d == 16'h0029 && tr == pw && $time - tu >= 1000) frz <= #1000 1'b1;
			tu = $time;
		end else if (d == 16'h0025 && mode == 3) uc = 1;
		else if (d == 16'h00A0 && mode > 0) pg = 1;
		else if (d == 16'h0080) er = mode != 1;
		else if (er && d == 16'h0030) begin
			er = 0;
			if (mode == 4 && frz) nv.delete();
		end else if (d == 16'h0090 && mode > 0) ex = 1;
		else if (ex && d == 16'h0000) begin
			ex = 0;
			mode = 0;
		end else if (h2 == {23'h555, 16'h00AA} && h1 == {23'h2AA, 16'h0055} && a == 23'h555)
			case (d)
				16'h0088: mode = 1;
				16'h0040: mode = 2;
				16'h0060: mode = 3;
				16'h00C0: mode = 4;
				16'h0050: mode = 5;
				16'h00E0: mode = 6;
				default: ;
			endcase
		h2 = h1;
		h1 = {a, d};
	end
	always @(negedge oeN) if (!ceN)
		case (mode)
			0: q = ~a[15:0];
			1: q = ext.exists(a[6:0]) ? ext[a[6:0]] : 16'hFFFF;
			2: q = lreg;
			3: q = lreg[PWL] ? pw[a[1:0]*16 +: 16] : 16'h00FF;
			4: q = {15'h0, nv.exists(a) ? nv[a] : 1'b0};
			5: q = {15'h0, frz};
			default: q = {15'h0, vb.exists(a) ? vb[a] : 1'b1};
		endcase
	always @(negedge flashRstN) begin
		mode = 0;
		pg = 0;
		er = 0;
		ex = 0;
		uc = 0;
		vb.delete();
	end
endmodule // flash_model

// ---- tb/flash_prot_host_props.sv ----
// Checker for APB answers and flash pin timing of the protection host
module flash_prot_host_props #(
	parameter ADDR_W = 23
) (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire [ADDR_W-1:0] flashAddr,
	input wire [15:0] dqOut,
	input wire dqOe,
	input wire ceN,
	input wire weN,
	input wire oeN,
	input wire flashRstN,
	input wire byteN
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	ready_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	word_mode_a: assert property (byteN) else $error("byte mode selected");
	strobe_select_a: assert property (!weN |-> !ceN && dqOe) else $error("bad strobe");
	strobe_width_a: assert property ($fell(weN) |=> !weN[*8] ##1 weN)
		else $error("write strobe width");
	read_excl_a: assert property (!oeN |-> weN && !dqOe && !ceN) else $error("bad read");
	rst_width_a: assert property ($fell(flashRstN) |-> ##124 !flashRstN ##1 flashRstN)
		else $error("reset pulse width");
	write_hold_a: assert property (!weN && !$fell(weN) |->
		$stable(flashAddr) && $stable(dqOut)) else $error("write data moved");
	write_setup_a: assert property ($fell(weN) |-> $past(ceN, 3) == 1'b0)
		else $error("write setup short");
	cover property ($fell(weN));
	cover property ($fell(oeN));
	cover property ($fell(flashRstN));
	cover property (pslverr);
endmodule // flash_prot_host_props

// ---- tb/tb.sv ----
// Testbench driving protection commands over APB into a flash model
`include "flash_prot_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, dqOe, ceN, weN, oeN, flashRstN, byteN;
	logic [22:0] flashAddr;
	logic [15:0] dqOut, dqIn;
	int errors = 0, total_checks = 0, cyc = 0;
	always #2 clock = ~clock;
	flash_prot_host flash_prot_host_inst (.clock, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flashAddr, .dqOut, .dqOe, .dqIn, .ceN, .weN,
		.oeN, .flashRstN, .byteN);
	flash_model flash_model_inst (.ceN, .weN, .oeN, .flashRstN, .flashAddr, .dqOut, .dqIn);
	// ----------------------------
	// Bus tasks
	// ----------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 0;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic look(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input string n);
		xfer(0, a, 0);
		chk(n, e, rd & m);
	endtask
	task automatic cmd(input logic [4:0] c, input logic [31:0] ad = 0);
		xfer(1, `REG_ADDR, ad);
		xfer(1, `REG_CMD, {27'h0, c});
		do xfer(0, `REG_STAT, 0); while (rd[`STAT_BUSY] !== 1'b0);
	endtask
	task automatic md(input logic [2:0] m);
		look(`REG_STAT, {25'h0, m, 4'h0}, 32'h70, "mode");
	endtask
	task automatic word(input logic [4:0] c, input logic [31:0] ad, input logic [15:0] e);
		cmd(c, ad);
		look(`REG_RDAT, {16'h0, e}, 32'hFFFF, "read word");
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ceiling well above the longest expected run
	always @(posedge clock) if (++cyc == 40000) begin
		errors++;
		results();
	end
	// ----------------------------
	// Main sequence
	// ----------------------------
	initial begin
		repeat (4) @(posedge clock);
		rst <= 0;
		look(`REG_STAT, 0, 32'h73, "stat after reset");
		cmd(`CMD_ENTER_EXT);
		md(1);
		word(`CMD_ARRAY_READ, 5, 16'hFFFF);
		cmd(`CMD_EXIT_EXT);
		md(0);
		word(`CMD_ARRAY_READ, 5, 16'hFFFA);
		cmd(`CMD_ENTER_PW);
		cmd(`CMD_PW_READ);
		look(`REG_PRLO, 32'hFFFFFFFF, 32'hFFFFFFFF, "blank pw lo");
		look(`REG_PRHI, 32'hFFFFFFFF, 32'hFFFFFFFF, "blank pw hi");
		xfer(1, `REG_PWLO, 32'h89ABCDEF);
		xfer(1, `REG_PWHI, 32'h01234567);
		cmd(`CMD_PW_PROG);
		cmd(`CMD_PW_READ);
		look(`REG_PRLO, 32'h89ABCDEF, 32'hFFFFFFFF, "pw lo");
		look(`REG_PRHI, 32'h01234567, 32'hFFFFFFFF, "pw hi");
		cmd(`CMD_EXIT_PROT);
		md(0);
		cmd(`CMD_ENTER_LREG);
		md(2);
		xfer(1, `REG_DATA, 32'h0000FFFE);
		cmd(`CMD_LREG_PROG);
		word(`CMD_LREG_READ, 0, 16'hFFFE);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_NVP);
		md(4);
		cmd(`CMD_NVP_PROG, 3);
		word(`CMD_NVP_READ, 3, 16'h0001);
		cmd(`CMD_FRZ_PROG);
		look(`REG_STAT, 32'h42, 32'h72, "refused kept mode");
		xfer(1, `REG_STAT, 32'h2);
		look(`REG_STAT, 32'h40, 32'h72, "refused cleared");
		cmd(`CMD_NVP_CLRALL);
		word(`CMD_NVP_READ, 3, 16'h0000);
		cmd(`CMD_NVP_PROG, 3);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_FRZ);
		cmd(`CMD_FRZ_PROG);
		word(`CMD_FRZ_READ, 0, 16'h0000);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_NVP);
		cmd(`CMD_NVP_CLRALL);
		word(`CMD_NVP_READ, 3, 16'h0001);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_PW);
		md(3);
		cmd(`CMD_PW_UNLOCK);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_FRZ);
		word(`CMD_FRZ_READ, 0, 16'h0001);
		cmd(`CMD_EXIT_PROT);
		// Wrong unlock then right one at once: spacing must still be kept
		cmd(`CMD_ENTER_FRZ);
		cmd(`CMD_FRZ_PROG);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_PW);
		xfer(1, `REG_PWLO, 32'h00000000);
		cmd(`CMD_PW_UNLOCK);
		xfer(1, `REG_PWLO, 32'h89ABCDEF);
		cmd(`CMD_PW_UNLOCK);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_FRZ);
		word(`CMD_FRZ_READ, 0, 16'h0001);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_VOL);
		md(6);
		word(`CMD_VOL_READ, 2, 16'h0001);
		cmd(`CMD_VOL_PROG, 2);
		word(`CMD_VOL_READ, 2, 16'h0000);
		cmd(`CMD_VOL_CLR, 2);
		word(`CMD_VOL_READ, 2, 16'h0001);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_LREG);
		xfer(1, `REG_DATA, 32'h0000FFFB);
		cmd(`CMD_LREG_PROG);
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_PW);
		cmd(`CMD_PW_READ);
		look(`REG_PRLO, 32'h00FF00FF, 32'hFFFFFFFF, "locked pw lo");
		cmd(`CMD_EXIT_PROT);
		cmd(`CMD_ENTER_EXT);
		cmd(`CMD_NVP_CLRALL);
		look(`REG_STAT, 32'h12, 32'h72, "erase refused in ext");
		xfer(1, `REG_STAT, 32'h2);
		cmd(`CMD_HW_RESET);
		md(0);
		word(`CMD_ARRAY_READ, 5, 16'hFFFA);
		xfer(0, 8'h40, 0);
		chk("unmapped error", 1, {31'h0, err});
		xfer(0, `REG_STAT, 0);
		chk("mapped okay", 0, {31'h0, err});
		results();
	end
endmodule // tb
bind flash_prot_host flash_prot_host_props #(.ADDR_W(ADDR_W)) props_inst (.clock, .rst,
	.psel, .penable, .pready, .pslverr, .flashAddr, .dqOut, .dqOe, .ceN, .weN, .oeN,
	.flashRstN, .byteN);
